// ===== verilog/mmp_regs.vh
`ifndef MMP_REGS_VH
`define MMP_REGS_VH
// Addressing mode codes
`define MMP_MODE_DREG 3'h0
`define MMP_MODE_AREG 3'h1
`define MMP_MODE_IND 3'h2
`define MMP_MODE_POSTINC 3'h3
`define MMP_MODE_PREDEC 3'h4
`define MMP_MODE_DISP 3'h5
`define MMP_MODE_INDEX 3'h6
`define MMP_MODE_EXT 3'h7
// Register sub-codes of mode 7
`define MMP_EXT_ABSW 3'h0
`define MMP_EXT_ABSL 3'h1
`define MMP_EXT_PCDISP 3'h2
`define MMP_EXT_PCIDX 3'h3
`define MMP_EXT_IMM 3'h4
// Peripheral move opmodes
`define MMP_PM_WORD_LOAD 3'h4
`define MMP_PM_LONG_LOAD 3'h5
`define MMP_PM_WORD_STORE 3'h6
`define MMP_PM_LONG_STORE 3'h7
// Peripheral byte stride
`define MMP_PM_STRIDE 32'h00000002
// Multi-move address step per bus word
`define MMP_MM_STEP 32'h00000002
// Flag bit positions in condition_flags
`define MMP_FLAG_C 0
`define MMP_FLAG_V 1
`define MMP_FLAG_Z 2
`define MMP_FLAG_N 3
`define MMP_FLAG_X 4
// Reset value of flags
`define MMP_FLAGS_RST 5'h00
// Operation select codes
`define MMP_OP_MULTI_LOAD 3'h1
`define MMP_OP_PERIPH 3'h2
`define MMP_OP_QUICK 3'h3
`define MMP_OP_MUL_WORD 3'h4
`define MMP_OP_MUL_LONG 3'h5
`endif

// ===== verilog/mmp_core.v
`timescale 1ns/1ns
`include "mmp_regs.vh"
module mmp_core (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Instruction issue
  input wire opStart,
  input wire [2:0] opSel,
  input wire [15:0] opWord,
  input wire [15:0] extWord,
  input wire [31:0] srcOperand,
  input wire [31:0] eaAddr,
  output wire opReady,
  output reg opDone_ff,
  output reg illegalOp_ff,
  // Register file access
  output wire [3:0] regRdIdx,
  input wire [31:0] regRdData,
  output wire [3:0] regRdIdx2,
  input wire [31:0] regRdData2,
  output reg regWe_ff,
  output reg [3:0] regWrIdx_ff,
  output reg [31:0] regWrData_ff,
  // Byte memory port
  output reg memReq_ff,
  output reg memWrite_ff,
  output reg [31:0] memAddr_ff,
  output reg [15:0] memWrData_ff,
  input wire memAck,
  input wire [15:0] memRdData,
  // Flags
  output reg [4:0] condFlags_ff
);
  // One-hot states
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_MULTI = 5'h02;
  localparam [4:0] ST_PBYTE = 5'h04;
  localparam [4:0] ST_WRHI = 5'h08;
  localparam [4:0] ST_DONE = 5'h10;
  reg [4:0] state_ff;
  // Working registers
  reg [15:0] mask_ff;
  reg [31:0] addr_ff;
  reg longSz_ff;
  reg [3:0] dIdx_ff;
  reg [2:0] pmMode_ff;
  reg [1:0] byteCnt_ff;
  reg [31:0] pData_ff;
  reg [31:0] hiWord_ff;
  reg [3:0] hiIdx_ff;
  reg [15:0] lowHalf_ff;
  reg halfSeen_ff;
  // Decode fields
  wire [2:0] eaMode = opWord[5:3];
  wire [2:0] eaReg = opWord[2:0];
  wire [2:0] dataReg = opWord[11:9];
  wire [2:0] pmOpmode = opWord[8:6];
  wire transferDirectionBit = opWord[10];
  wire mulSizeBit = extWord[10];
  wire [2:0] productLowRegister = extWord[14:12];
  wire [2:0] productHighRegister = extWord[2:0];
  reg multiModeOk;
  always @*
  begin
    case (eaMode)
      `MMP_MODE_IND, `MMP_MODE_POSTINC, `MMP_MODE_DISP, `MMP_MODE_INDEX:
        multiModeOk = 1'b1;
      `MMP_MODE_EXT:
        multiModeOk = (eaReg <= `MMP_EXT_PCIDX);
      default:
        multiModeOk = 1'b0;
    endcase
  end
  // data modes, immediate allowed, An direct not
  reg mulModeOk;
  always @*
  begin
    case (eaMode)
      `MMP_MODE_AREG:
        mulModeOk = 1'b0;
      `MMP_MODE_EXT:
        mulModeOk = (eaReg <= `MMP_EXT_IMM);
      default:
        mulModeOk = 1'b1;
    endcase
  end
  // Legality per selected operation
  reg opLegal;
  always @*
  begin
    case (opSel)
      `MMP_OP_MULTI_LOAD:
        opLegal = multiModeOk & transferDirectionBit;
      `MMP_OP_PERIPH:
        opLegal = pmOpmode[2];
      `MMP_OP_QUICK:
        opLegal = ~opWord[8];
      `MMP_OP_MUL_WORD:
        opLegal = mulModeOk;
      `MMP_OP_MUL_LONG:
        opLegal = mulModeOk;
      default:
        opLegal = 1'b0;
    endcase
  end
  reg [15:0] normMask;
  integer i;
  always @*
  begin
    for (i = 0; i < 16; i = i + 1)
    begin
      if (eaMode == `MMP_MODE_PREDEC)
        normMask[i] = extWord[15 - i];
      else
        normMask[i] = extWord[i];
    end
  end
  // Lowest set bit of live mask, sent first
  reg [3:0] lowIdx;
  integer k;
  always @*
  begin
    lowIdx = 4'h0;
    for (k = 15; k >= 0; k = k - 1)
    begin
      if (mask_ff[k])
        lowIdx = k[3:0];
    end
  end
  // word operands from low halves, signed
  wire signed [31:0] mulWordProd =
    $signed(regRdData[15:0]) * $signed(srcOperand[15:0]);
  wire signed [63:0] mulLongProd =
    $signed(regRdData) * $signed(srcOperand);
  // overflow when high half is not sign copy
  wire mulLongOvf = (mulLongProd[63:32] != {32{mulLongProd[31]}});
  wire [31:0] quickVal = {{24{opWord[7]}}, opWord[7:0]};
  wire [31:0] pmAddr = regRdData2 + {{16{extWord[15]}}, extWord};
  // Register read selects
  // data field reads Dn, product low field for long multiply; base field reads An
  assign regRdIdx = (opSel == `MMP_OP_MUL_LONG) ?
    {1'b0, productLowRegister} : {1'b0, dataReg};
  assign regRdIdx2 = {1'b1, eaReg};
  assign opReady = (state_ff == ST_IDLE);
  // Byte lane to send, high byte first
  // most significant byte leads
  reg [7:0] outByte;
  always @*
  begin
    case (byteCnt_ff)
      2'h3: outByte = pData_ff[31:24];
      2'h2: outByte = pData_ff[23:16];
      2'h1: outByte = pData_ff[15:8];
      default: outByte = pData_ff[7:0];
    endcase
  end
  // Main sequencer; flags and writes registered
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      state_ff <= ST_IDLE;
      opDone_ff <= 1'b0;
      illegalOp_ff <= 1'b0;
      regWe_ff <= 1'b0;
      regWrIdx_ff <= 4'h0;
      regWrData_ff <= 32'h00000000;
      memReq_ff <= 1'b0;
      memWrite_ff <= 1'b0;
      memAddr_ff <= 32'h00000000;
      memWrData_ff <= 16'h0000;
      condFlags_ff <= `MMP_FLAGS_RST;
      mask_ff <= 16'h0000;
      addr_ff <= 32'h00000000;
      longSz_ff <= 1'b0;
      dIdx_ff <= 4'h0;
      pmMode_ff <= 3'h0;
      byteCnt_ff <= 2'h0;
      pData_ff <= 32'h00000000;
      hiWord_ff <= 32'h00000000;
      hiIdx_ff <= 4'h0;
      lowHalf_ff <= 16'h0000;
      halfSeen_ff <= 1'b0;
    end
    else
    begin
      // Pulses default low
      opDone_ff <= 1'b0;
      illegalOp_ff <= 1'b0;
      regWe_ff <= 1'b0;
      case (state_ff)
        ST_IDLE:
        begin
          if (opStart && !opLegal)
          begin
            illegalOp_ff <= 1'b1;
            opDone_ff <= 1'b1;
          end
          else if (opStart)
          begin
            case (opSel)
              `MMP_OP_MULTI_LOAD:
              begin
                mask_ff <= normMask;
                addr_ff <= eaAddr;
                longSz_ff <= opWord[6];
                halfSeen_ff <= 1'b0;
                state_ff <= (normMask == 16'h0000) ? ST_DONE : ST_MULTI;
              end
              `MMP_OP_PERIPH:
              begin
                pmMode_ff <= pmOpmode;
                addr_ff <= pmAddr;
                dIdx_ff <= {1'b0, dataReg};
                pData_ff <= regRdData;
                byteCnt_ff <= pmOpmode[0] ? 2'h3 : 2'h1;
                state_ff <= ST_PBYTE;
              end
              `MMP_OP_QUICK:
              begin
                regWe_ff <= 1'b1;
                regWrIdx_ff <= {1'b0, dataReg};
                regWrData_ff <= quickVal;
                // N Z from result, V C cleared, X kept
                condFlags_ff[`MMP_FLAG_N] <= quickVal[31];
                condFlags_ff[`MMP_FLAG_Z] <= (quickVal == 32'h00000000);
                condFlags_ff[`MMP_FLAG_V] <= 1'b0;
                condFlags_ff[`MMP_FLAG_C] <= 1'b0;
                state_ff <= ST_DONE;
              end
              `MMP_OP_MUL_WORD:
              begin
                regWe_ff <= 1'b1;
                regWrIdx_ff <= {1'b0, dataReg};
                regWrData_ff <= mulWordProd;
                condFlags_ff[`MMP_FLAG_N] <= mulWordProd[31];
                condFlags_ff[`MMP_FLAG_Z] <= (mulWordProd == 32'h00000000);
                condFlags_ff[`MMP_FLAG_V] <= 1'b0;
                condFlags_ff[`MMP_FLAG_C] <= 1'b0;
                state_ff <= ST_DONE;
              end
              default:
              begin
                // low word to low register first
                regWe_ff <= 1'b1;
                regWrIdx_ff <= {1'b0, productLowRegister};
                regWrData_ff <= mulLongProd[31:0];
                hiWord_ff <= mulLongProd[63:32];
                hiIdx_ff <= {1'b0, productHighRegister};
                condFlags_ff[`MMP_FLAG_C] <= 1'b0;
                // N Z on the result actually kept
                if (mulSizeBit)
                begin
                  condFlags_ff[`MMP_FLAG_N] <= mulLongProd[63];
                  condFlags_ff[`MMP_FLAG_Z] <=
                    (mulLongProd == 64'h0000000000000000);
                  condFlags_ff[`MMP_FLAG_V] <= 1'b0;
                  state_ff <= ST_WRHI;
                end
                else
                begin
                  condFlags_ff[`MMP_FLAG_N] <= mulLongProd[31];
                  condFlags_ff[`MMP_FLAG_Z] <=
                    (mulLongProd[31:0] == 32'h00000000);
                  // V only in 32-bit result form
                  condFlags_ff[`MMP_FLAG_V] <= mulLongOvf;
                  state_ff <= ST_DONE;
                end
              end
            endcase
          end
        end
        ST_WRHI:
        begin
          // High half of 64-bit product
          regWe_ff <= 1'b1;
          regWrIdx_ff <= hiIdx_ff;
          regWrData_ff <= hiWord_ff;
          state_ff <= ST_DONE;
        end
        ST_MULTI:
        begin
          // One bus word per request, held until acked
          if (!memReq_ff)
          begin
            memReq_ff <= 1'b1;
            memWrite_ff <= 1'b0;
            memAddr_ff <= addr_ff;
          end
          else if (memAck)
          begin
            memReq_ff <= 1'b0;
            addr_ff <= addr_ff + `MMP_MM_STEP;
            if (longSz_ff && !halfSeen_ff)
            begin
              // Upper half of a long comes first
              lowHalf_ff <= memRdData;
              halfSeen_ff <= 1'b1;
            end
            else
            begin
              halfSeen_ff <= 1'b0;
              regWe_ff <= 1'b1;
              regWrIdx_ff <= lowIdx;
              regWrData_ff <= longSz_ff ? {lowHalf_ff, memRdData} :
                {{16{memRdData[15]}}, memRdData};
              mask_ff[lowIdx] <= 1'b0;
              if ((mask_ff & ~(16'h0001 << lowIdx)) == 16'h0000)
                state_ff <= ST_DONE;
            end
          end
        end
        ST_PBYTE:
        begin
          if (!memReq_ff)
          begin
            memReq_ff <= 1'b1;
            memWrite_ff <= pmMode_ff[1];
            memAddr_ff <= addr_ff;
            memWrData_ff <= {8'h00, outByte};
          end
          else if (memAck)
          begin
            memReq_ff <= 1'b0;
            memWrite_ff <= 1'b0;
            addr_ff <= addr_ff + `MMP_PM_STRIDE;
            if (!pmMode_ff[1])
              pData_ff <= {pData_ff[23:0], memRdData[7:0]};
            byteCnt_ff <= byteCnt_ff - 2'h1;
            if (byteCnt_ff == 2'h0)
            begin
              if (!pmMode_ff[1])
              begin
                // Word load keeps register upper half
                regWe_ff <= 1'b1;
                regWrIdx_ff <= dIdx_ff;
                regWrData_ff <= pmMode_ff[0] ?
                  {pData_ff[23:0], memRdData[7:0]} :
                  {regRdData[31:16], pData_ff[7:0], memRdData[7:0]};
              end
              state_ff <= ST_DONE;
            end
          end
        end
        ST_DONE:
        begin
          opDone_ff <= 1'b1;
          state_ff <= ST_IDLE;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule // mmp_core

// ===== test/mmp_mem_model.sv
`timescale 1ns/1ns
module mmp_mem_model (
  // Clock
  input wire clk,
  // Request from the core
  input wire memReq_ff,
  input wire memWrite_ff,
  input wire [31:0] memAddr_ff,
  input wire [15:0] memWrData_ff,
  // Answer side, lat sets the wait
  input wire [3:0] lat,
  output reg memAck,
  output reg [15:0] memRdData
);
  // Byte store, low address bits only
  reg [7:0] mem [0:255];
  reg [3:0] waitCnt;
  initial
  begin
    memAck = 1'b0;
    memRdData = 16'h0000;
    waitCnt = 4'h0;
  end
  // Ack after lat idle cycles; read data only valid with ack
  always @(posedge clk)
  begin
    if (memReq_ff && !memAck && waitCnt >= lat)
    begin
      memAck <= 1'b1;
      waitCnt <= 4'h0;
      if (memWrite_ff)
        mem[memAddr_ff[7:0]] <= memWrData_ff[7:0];
      memRdData <= {memAddr_ff[7:0], ~memAddr_ff[7:0]};
    end
    else
    begin
      // Stale data flips so nothing leans on it
      memAck <= 1'b0;
      memRdData <= ~memRdData;
      if (memReq_ff && !memAck)
        waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule // mmp_mem_model

// ===== test/mmp_core_props.sv
`timescale 1ns/1ns
module mmp_core_props (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Issue
  input wire opStart,
  input wire [2:0] opSel,
  input wire [15:0] opWord,
  input wire [15:0] extWord,
  input wire [31:0] srcOperand,
  input wire opReady,
  input wire opDone_ff,
  input wire illegalOp_ff,
  // Register file
  input wire [31:0] regRdData,
  input wire [31:0] regRdData2,
  input wire regWe_ff,
  input wire [3:0] regWrIdx_ff,
  input wire [31:0] regWrData_ff,
  // Memory and flags
  input wire memReq_ff,
  input wire [31:0] memAddr_ff,
  input wire memAck,
  input wire [4:0] condFlags_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Accepted issue; An direct source
  wire go = opStart & opReady;
  wire anSrc = opWord[5:3] == 3'h1;
  // Low 32 bits of a signed word product
  function [31:0] smul(input [15:0] a, input [15:0] b);
    smul = {{16{a[15]}}, a} * {{16{b[15]}}, b};
  endfunction
  sequence s_low;
    regWe_ff && regWrIdx_ff == {1'b0, $past(extWord[14:12])};
  endsequence
  sequence s_high;
    regWe_ff && regWrIdx_ff == {1'b0, $past(extWord[2:0], 2)};
  endsequence
  a_quick_load: assert property (go && opSel == 3'h3 |=> regWe_ff
    && regWrData_ff == {{24{$past(opWord[7])}}, $past(opWord[7:0])})
    else $error("quick load value wrong");
  a_quick_flags: assert property (go && opSel == 3'h3 |=>
    condFlags_ff[3:0] == {$past(opWord[7]), $past(opWord[7:0]) == 8'h00,
    2'b00}) else $error("quick load flags wrong");
  a_quick_done: assert property (go && opSel == 3'h3 |=> ##1 opDone_ff)
    else $error("quick load done late");
  a_mul_word: assert property (go && opSel == 3'h4 && !anSrc |=>
    regWe_ff && regWrData_ff == smul($past(srcOperand[15:0]),
    $past(regRdData[15:0]))) else $error("word product wrong");
  a_illegal_quiet: assert property (go && opSel == 3'h1 &&
    (opWord[5:3] == 3'h0 || anSrc || opWord[5:3] == 3'h4) |=>
    illegalOp_ff && opDone_ff && !regWe_ff && !memReq_ff)
    else $error("illegal mode not refused");
  a_periph_addr: assert property (go && opSel == 3'h2 |=> ##1 memReq_ff &&
    memAddr_ff == $past(regRdData2, 2) + {{16{$past(extWord[15], 2)}},
    $past(extWord, 2)}) else $error("peripheral address wrong");
  a_req_hold: assert property (memReq_ff && !memAck |=>
    memReq_ff && $stable(memAddr_ff)) else $error("request dropped");
  a_mul_long: assert property (go && opSel == 3'h5 && extWord[10]
    && !anSrc |=> s_low ##1 s_high ##1 opDone_ff)
    else $error("long product write order wrong");
  a_extend_kept: assert property ($stable(condFlags_ff[4]))
    else $error("extend flag changed");
endmodule // mmp_core_props
bind mmp_core mmp_core_props mmp_core_props_i (.clk, .rstn, .opStart,
  .opSel, .opWord, .extWord, .srcOperand, .opReady, .opDone_ff,
  .illegalOp_ff, .regRdData, .regRdData2, .regWe_ff, .regWrIdx_ff,
  .regWrData_ff, .memReq_ff, .memAddr_ff, .memAck, .condFlags_ff);

// ===== test/tb.sv
`timescale 1ns/1ns
module tb;
  // Stimulus and register file
  reg clk, rstn, opStart;
  reg [2:0] opSel;
  reg [15:0] opWord, extWord;
  reg [31:0] srcOperand, eaAddr;
  reg [3:0] lat;
  reg [31:0] rf [0:15];
  reg [7:0] d;
  wire opReady, opDone_ff, illegalOp_ff, regWe_ff;
  wire memReq_ff, memWrite_ff, memAck;
  wire [3:0] regRdIdx, regRdIdx2, regWrIdx_ff;
  wire [31:0] regWrData_ff, memAddr_ff;
  wire [15:0] memWrData_ff, memRdData;
  wire [4:0] condFlags_ff;
  wire [31:0] regRdData = rf[regRdIdx];
  wire [31:0] regRdData2 = rf[regRdIdx2];
  integer error_cnt, comparisons, i;
  // Boundary immediates; refused multi-move modes
  localparam [23:0] QD = 24'h80007F;
  localparam [23:0] MT = {6'o00, 6'o10, 6'o40, 6'o74};
  mmp_core mmp_core_i (.clk, .rstn, .opStart, .opSel, .opWord, .extWord,
    .srcOperand, .eaAddr, .opReady, .opDone_ff, .illegalOp_ff, .regRdIdx,
    .regRdData, .regRdIdx2, .regRdData2, .regWe_ff, .regWrIdx_ff,
    .regWrData_ff, .memReq_ff, .memWrite_ff, .memAddr_ff, .memWrData_ff,
    .memAck, .memRdData, .condFlags_ff);
  mmp_mem_model mmp_mem_model_i (.clk, .memReq_ff, .memWrite_ff,
    .memAddr_ff, .memWrData_ff, .lat, .memAck, .memRdData);
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Register file takes the core's write pulses
  always @(posedge clk)
    if (regWe_ff === 1'b1)
      rf[regWrIdx_ff] <= regWrData_ff;
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      if (error_cnt == 0 && comparisons > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // One issue; operands held until done, bounded wait
  task op(input [2:0] s, input [15:0] w, input [15:0] e,
    input [31:0] src, input [31:0] ea);
    integer n;
    begin
      @(posedge clk);
      opStart <= 1'b1;
      opSel <= s;
      opWord <= w;
      extWord <= e;
      srcOperand <= src;
      eaAddr <= ea;
      @(posedge clk);
      opStart <= 1'b0;
      n = 0;
      @(negedge clk);
      while (opDone_ff !== 1'b1 && n < 100)
      begin
        @(negedge clk);
        n = n + 1;
      end
      if (n == 100)
        chk(32'h0, 32'h1);
    end
  endtask
  // Hang guard
  initial
  begin
    repeat (3000) @(posedge clk);
    error_cnt = error_cnt + 1;
    final_report;
  end
  initial
  begin
    {opStart, opSel, opWord, extWord, srcOperand, eaAddr, lat} = 0;
    rstn = 1'b0;
    error_cnt = 0;
    comparisons = 0;
    for (i = 0; i < 16; i = i + 1)
      rf[i] = 32'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 3; i = i + 1)
    begin
      d = QD[i*8 +: 8];
      op(3'h3, {4'h7, 3'h3, 1'b0, d}, 16'h0000, 0, 0);
      chk(rf[3], {{24{d[7]}}, d});
      chk({27'h0, condFlags_ff}, {28'h0, d[7], d == 8'h00, 2'b00});
    end
    rf[2] = 32'hFFFF0003;
    op(3'h4, 16'hC5C0, 16'h0000, 32'h1234FFFE, 0);
    chk(rf[2], 32'hFFFFFFFA);
    chk({27'h0, condFlags_ff}, 32'h08);
    rf[1] = 32'h00010000;
    op(3'h5, 16'h4C00, 16'h1800, 32'h00010000, 0);
    chk(rf[1], 32'h0);
    chk({27'h0, condFlags_ff}, 32'h06);
    rf[4] = 32'hFFFFFFFF;
    op(3'h5, 16'h4C00, 16'h4C05, 32'h2, 0);
    chk({rf[5], rf[4]} == 64'hFFFFFFFFFFFFFFFE, 1);
    rf[1] = 32'h5;
    op(3'h5, 16'h4C08, 16'h1800, 32'h3, 0);
    chk({31'h0, illegalOp_ff}, 1);
    chk(rf[1], 32'h5);
    op(3'h5, 16'h4C3C, 16'h1800, 32'h3, 0);
    chk(rf[1], 32'hF);
    rf[0] = 32'h9;
    for (i = 0; i < 4; i = i + 1)
    begin
      op(3'h1, {10'b0100110010, MT[i*6 +: 6]}, 16'h0001, 0, 32'h80);
      chk({31'h0, illegalOp_ff}, 1);
      chk(rf[0], 32'h9);
    end
    lat = 4'h3;
    op(3'h1, 16'h4C98, 16'h8101, 0, 32'h80);
    chk(rf[0], 32'hFFFF807F);
    chk(rf[8], 32'hFFFF827D);
    chk(rf[15], 32'hFFFF847B);
    op(3'h1, 16'h4CFA, 16'h0002, 0, 32'h10);
    chk(rf[1], 32'h10EF12ED);
    lat = 4'h1;
    rf[6] = 32'hA1B2C3D4;
    rf[10] = 32'h40;
    op(3'h2, 16'h0DCA, 16'hFFF0, 0, 0);
    chk({mmp_mem_model_i.mem[48], mmp_mem_model_i.mem[50],
      mmp_mem_model_i.mem[52], mmp_mem_model_i.mem[54]},
      32'hA1B2C3D4);
    op(3'h2, 16'h0D8A, 16'hFFF0, 0, 0);
    chk({16'h0, mmp_mem_model_i.mem[48], mmp_mem_model_i.mem[50]},
      32'hC3D4);
    rf[7] = 32'h11112222;
    op(3'h2, 16'h0F0A, 16'hFFF0, 0, 0);
    chk(rf[7], 32'h1111CFCD);
    op(3'h2, 16'h014A, 16'hFFF0, 0, 0);
    chk(rf[0], 32'hCFCDCBC9);
    final_report;
  end
endmodule // tb
